// file: core/dlcc_defs.vh
// constants for the link cross-coupling dma block
`ifndef DLCC_DEFS_VH
`define DLCC_DEFS_VH

// ==========================================
// register byte offsets
`define DLCC_OFF_CSR      4'h0
`define DLCC_OFF_BAR      4'h4
`define DLCC_OFF_WCR      4'h8
`define DLCC_OFF_DATA     4'hc

// ==========================================
// control/status field positions
`define DLCC_CSR_GO       0
`define DLCC_CSR_DIR      1
`define DLCC_CSR_ATTN_OUT 2
`define DLCC_CSR_BURST_IN 3
`define DLCC_CSR_READY    7
`define DLCC_CSR_CYCLE    8
`define DLCC_CSR_STAT_C   9
`define DLCC_CSR_STAT_B   10
`define DLCC_CSR_STAT_A   11
`define DLCC_CSR_ATTN     13
`define DLCC_CSR_LINK_EN  14

// ==========================================
// timing
`define DLCC_CLK_NS       10
`define DLCC_GO_PULSE_NS  100
`define DLCC_GO_PULSE_CYC ((`DLCC_GO_PULSE_NS + `DLCC_CLK_NS - 1) / `DLCC_CLK_NS)
`define DLCC_CYC_NS       200
`define DLCC_CYC_CYC      ((`DLCC_CYC_NS + `DLCC_CLK_NS - 1) / `DLCC_CLK_NS)

`endif

// file: core/dlcc_one_shot.v
// fixed-width pulse stretcher for the go strobe
`timescale 1ns/1ps
`default_nettype none
module dlcc_one_shot #(
	parameter WIDTH = 10
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire trig_i,
	output reg  pulse_o
);
	reg [7:0] cnt;
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt     <= 8'h00;
			pulse_o <= 1'b0;
		end else if (trig_i && cnt == 8'h00) begin
			cnt     <= WIDTH[7:0];
			pulse_o <= 1'b1;
		end else if (cnt != 8'h00) begin
			cnt     <= cnt - 8'h01;
			pulse_o <= (cnt != 8'h01);
		end
	end
endmodule
`default_nettype wire

// file: core/dlcc_edge_det.v
// rising and falling edge detector for link inputs
`timescale 1ns/1ps
`default_nettype none
module dlcc_edge_det (
	input  wire clk_i,
	input  wire rst_i,
	input  wire lvl_i,
	output wire rise_o,
	output wire fall_o
);
	reg prev;
	always @(posedge clk_i) begin
		if (rst_i) begin
			prev <= lvl_i;
		end else begin
			prev <= lvl_i;
		end
	end
	assign rise_o = lvl_i & ~prev;
	assign fall_o = ~lvl_i & prev;
endmodule
`default_nettype wire

// file: core/dlcc_link.v
// link-mode dma control block with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "dlcc_defs.vh"
module dlcc_link #(
	parameter GO_PULSE_CYC = `DLCC_GO_PULSE_CYC,
	parameter CYC_CYC      = `DLCC_CYC_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        link_ready_report_disable_switch,
	input  wire        peer_func1_i,
	input  wire        peer_func2_i,
	input  wire        peer_func3_i,
	input  wire        peer_ready_i,
	input  wire        peer_power_ok_i,
	input  wire        cycle_request_primary_in,
	input  wire        dma_error_i,
	input  wire        mem_ack_i,
	input  wire [15:0] mem_rdata_i,
	input  wire [15:0] link_data_i,
	output reg         mem_req_o,
	output reg         mem_we_o,
	output reg  [15:0] mem_addr_o,
	output reg  [15:0] mem_wdata_o,
	output reg  [15:0] link_data_o,
	output wire        direction_control_out,
	output wire        peer_attention_out,
	output wire        peer_burst_inhibit_out,
	output reg         busy_o,
	output reg         ready_o,
	output wire        go_pulse_o,
	output reg         attn_o
);
	// ==========================================
	// state
	localparam ST_IDLE = 3'b001;
	localparam ST_MEM  = 3'b010;
	localparam ST_HOLD = 3'b100;

	reg [2:0]  state;
	reg [15:0] csr_fn;
	reg        link_en;
	reg        cycle_ff;
	reg [15:0] bar;
	reg [15:0] wcr;
	reg [7:0]  hold_cnt;
	wire       bus_req;
	wire       wr_csr;
	wire       go_wr;
	wire       cyc_wr;
	wire       attn_rise;
	wire       pwr_rise;
	wire       pwr_fall;
	wire       req_rise;

	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign wr_csr  = bus_req & we_i & (adr_i == `DLCC_OFF_CSR) & sel_i[0];
	assign go_wr   = wr_csr & dat_i[`DLCC_CSR_GO];
	assign cyc_wr  = bus_req & we_i & (adr_i == `DLCC_OFF_CSR) & sel_i[1] & dat_i[`DLCC_CSR_CYCLE];

	// ==========================================
	// static function outputs
	assign direction_control_out  = csr_fn[`DLCC_CSR_DIR];
	assign peer_attention_out     = csr_fn[`DLCC_CSR_ATTN_OUT];
	assign peer_burst_inhibit_out = csr_fn[`DLCC_CSR_BURST_IN];

	// ==========================================
	// go one-shot and edge detectors
	dlcc_one_shot #(.WIDTH(GO_PULSE_CYC)) u_go (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.trig_i  (go_wr),
		.pulse_o (go_pulse_o)
	);

	dlcc_edge_det u_attn (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.lvl_i  (peer_func2_i),
		.rise_o (attn_rise),
		.fall_o ()
	);

	dlcc_edge_det u_pwr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.lvl_i  (peer_power_ok_i),
		.rise_o (pwr_rise),
		.fall_o (pwr_fall)
	);

	dlcc_edge_det u_req (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.lvl_i  (cycle_request_primary_in),
		.rise_o (req_rise),
		.fall_o ()
	);

	// ==========================================
	// register writes and attention flag
	always @(posedge clk_i) begin
		if (rst_i) begin
			csr_fn  <= 16'h0000;
			link_en <= 1'b0;
			attn_o  <= 1'b0;
			bar     <= 16'h0000;
		end else begin
			if (wr_csr) begin
				csr_fn  <= {12'h000, dat_i[3:1], 1'b0};
				link_en <= sel_i[1] ? dat_i[`DLCC_CSR_LINK_EN] : link_en;
			end
			if (bus_req & we_i & (adr_i == `DLCC_OFF_BAR) & sel_i[0])
				bar <= dat_i[15:0];
			else if (state == ST_HOLD && hold_cnt == 8'h01)
				bar <= bar + 16'h0002;
			// set wins over clear
			if (attn_rise | pwr_rise | pwr_fall)
				attn_o <= 1'b1;
			else if (wr_csr & dat_i[`DLCC_CSR_ATTN])
				attn_o <= 1'b0;
		end
	end

	// ==========================================
	// ready, cycle and dma sequencing
	always @(posedge clk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			ready_o     <= 1'b1;
			cycle_ff    <= 1'b0;
			busy_o      <= 1'b0;
			wcr         <= 16'h0000;
			hold_cnt    <= 8'h00;
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= 16'h0000;
			mem_wdata_o <= 16'h0000;
			link_data_o <= 16'h0000;
		end else begin
			if (bus_req & we_i & (adr_i == `DLCC_OFF_WCR) & sel_i[0])
				wcr <= dat_i[15:0];
			if (go_wr)
				ready_o <= 1'b0;
			if (cyc_wr & (~ready_o | go_wr))
				cycle_ff <= 1'b1;
			else if (req_rise & ~ready_o)
				cycle_ff <= 1'b1;
			case (state)
				ST_IDLE: begin
					if (cycle_ff & ~ready_o) begin
						cycle_ff   <= 1'b0;
						busy_o     <= 1'b1;
						mem_req_o  <= 1'b1;
						mem_we_o   <= csr_fn[`DLCC_CSR_DIR];
						mem_addr_o <= bar;
						mem_wdata_o <= link_data_i;
						state      <= ST_MEM;
					end
				end
				ST_MEM: begin
					if (mem_ack_i | dma_error_i) begin
						mem_req_o <= 1'b0;
						if (~mem_we_o)
							link_data_o <= mem_rdata_i;
						hold_cnt  <= CYC_CYC[7:0];
						state     <= ST_HOLD;
						if (dma_error_i)
							ready_o <= 1'b1;
					end
				end
				ST_HOLD: begin
					if (hold_cnt == 8'h01) begin
						busy_o <= 1'b0;
						wcr    <= wcr + 16'h0001;
						if (wcr == 16'hffff)
							ready_o <= 1'b1;
						state  <= ST_IDLE;
					end
					hold_cnt <= hold_cnt - 8'h01;
				end
				default: state <= ST_IDLE;
			endcase
			if (~ready_o & peer_func2_i & ~busy_o)
				ready_o <= 1'b1;
		end
	end

	// ==========================================
	// wishbone read and ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= bus_req;
			if (bus_req & ~we_i) begin
				case (adr_i)
					`DLCC_OFF_CSR: dat_o <= {16'h0000, 1'b0, link_en, attn_o, 1'b0,
						link_en & peer_func3_i,
						link_en & peer_func2_i,
						link_en & peer_func1_i,
						cycle_ff, ready_o, 3'b000, csr_fn[3:1], 1'b0};
					`DLCC_OFF_BAR: dat_o <= {16'h0000, bar[15:1],
						link_en & ~link_ready_report_disable_switch & peer_ready_i};
					`DLCC_OFF_WCR: dat_o <= {16'h0000, wcr};
					`DLCC_OFF_DATA: dat_o <= {16'h0000, link_data_i};
					default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: test/dlcc_link_sva.sv
// assertion checker for the link dma block
`timescale 1ns/1ps
`default_nettype none
module dlcc_link_sva #(
	parameter GO_PULSE_CYC = 10
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        we_i,
	input wire logic [3:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        link_ready_report_disable_switch,
	input wire logic        peer_func2_i,
	input wire logic        peer_power_ok_i,
	input wire logic        cycle_request_primary_in,
	input wire logic        mem_req_o,
	input wire logic        direction_control_out,
	input wire logic        peer_attention_out,
	input wire logic        peer_burst_inhibit_out,
	input wire logic        busy_o,
	input wire logic        ready_o,
	input wire logic        go_pulse_o,
	input wire logic        attn_o
);
	int   gcnt;
	logic go_wr;
	// ==========================================
	// helper: go pulse length and go write seen
	always @(posedge clk_i) begin
		if (rst_i) begin
			gcnt <= 0;
			go_wr <= 1'b0;
		end else begin
			gcnt <= go_pulse_o ? gcnt + 1 : 0;
			go_wr <= ack_o && we_i && adr_i == 4'h0 && sel_i[0] && dat_i[0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_go_width: assert property ($fell(go_pulse_o) |-> gcnt == GO_PULSE_CYC)
		else $error("go pulse width wrong");
	a_ready_clear: assert property ($fell(ready_o) |-> go_wr || (ack_o && we_i && adr_i == 4'h0 && dat_i[0]))
		else $error("ready cleared without go write");
	a_bar_off: assert property (ack_o && !we_i && adr_i == 4'h4 && link_ready_report_disable_switch |-> !dat_o[0])
		else $error("bar bit 0 set with switch on");
	a_outs_static: assert property (!ack_o && !$past(ack_o) && !$past(ack_o, 2)
		|-> $stable({direction_control_out, peer_attention_out, peer_burst_inhibit_out}))
		else $error("function output moved without write");
	a_attn_func: assert property ($rose(peer_func2_i) |-> ##[1:4] attn_o)
		else $error("no attention on peer function 2");
	a_attn_power: assert property ($changed(peer_power_ok_i) |-> ##[1:4] attn_o)
		else $error("no attention on peer power change");
	a_cycle_prompt: assert property ($rose(cycle_request_primary_in) && !ready_o && !busy_o |-> ##[1:8] busy_o)
		else $error("cycle request not answered");
	a_busy_dma: assert property ($rose(busy_o) |-> !ready_o && mem_req_o)
		else $error("busy without armed memory cycle");
	a_ready_attn: assert property (peer_func2_i && !ready_o && !busy_o |=> ready_o)
		else $error("ready not set on attention during dma");
endmodule
`default_nettype wire

// file: test/dlcc_peer.sv
// peer end model: answers each local cycle with one of its own
`timescale 1ns/1ps
`default_nettype none
module dlcc_peer #(
	parameter DLY = 3
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic busy_i,
	output var  logic req_o
);
	logic b_q;
	int   cnt;
	// peer request idles high and first rises only after the sender's cycle ends
	always @(posedge clk_i) begin
		b_q <= busy_i;
		if (rst_i) begin
			req_o <= 1'b1;
			cnt <= 0;
		end else if (b_q && !busy_i) begin
			req_o <= 1'b0;
			cnt <= DLY;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			req_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: test/tb.sv
// testbench for the link dma block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, mem_ack_i = 0;
	logic [3:0]  adr_i = 0, sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic        link_ready_report_disable_switch = 0, peer_func1_i = 0, peer_func2_i = 0, peer_func3_i = 0;
	logic        peer_ready_i = 0, peer_power_ok_i = 1, dma_error_i = 0, busy_q = 0;
	logic [15:0] mem_rdata_i = 16'h5a3c, link_data_i = 16'h0f0f, mem_addr_o, mem_wdata_o, link_data_o;
	logic        mem_req_o, mem_we_o, direction_control_out, peer_attention_out, peer_burst_inhibit_out;
	logic        busy_o, ready_o, go_pulse_o, attn_o;
	wire         cycle_request_primary_in;
	int          n_errors = 0, num_checks = 0, n_busy = 0;
	dlcc_link dut (.*);
	dlcc_peer #(.DLY(3)) peer (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy_o), .req_o(cycle_request_primary_in));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		mem_ack_i <= mem_req_o && !mem_ack_i;
		busy_q <= busy_o;
		if (busy_o === 1'b1 && busy_q === 1'b0)
			n_busy <= n_busy + 1;
	end
	// ==========================================
	// bus and compare tasks
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
	endtask
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		stop_test;
	end
	// ==========================================
	// tests
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk("ready", ready_o, 1);
		wb(1, 4'h0, 32'h4000);
		for (int i = 0; i < 8; i++) begin
			wb(1, 4'h0, 32'h4000 | (i << 1));
			{peer_func3_i, peer_func2_i, peer_func1_i} <= i[2:0];
			repeat (3) @(posedge clk_i);
			chk("func", {peer_burst_inhibit_out, peer_attention_out, direction_control_out}, i);
			wb(0, 4'h0, 0);
			chk("status", rd[11:9], i);
		end
		$display("test functions done");
		for (int i = 0; i < 4; i++) begin
			{link_ready_report_disable_switch, peer_ready_i} <= i[1:0];
			repeat (2) @(posedge clk_i);
			wb(0, 4'h4, 0);
			chk("bar0", rd[0], i == 1);
		end
		$display("test ready report done");
		{peer_func3_i, peer_func2_i, peer_func1_i} <= 3'h0;
		link_ready_report_disable_switch <= 0;
		for (int i = 0; i < 4; i++) begin
			wb(1, 4'h0, 32'h6000);
			repeat (2) @(posedge clk_i);
			chk("attn clr", attn_o, 0);
			if (i == 3)
				break;
			if (i == 0)
				peer_func2_i <= 1;
			else
				peer_power_ok_i <= ~peer_power_ok_i;
			repeat (4) @(posedge clk_i);
			chk("attn", attn_o, 1);
			peer_func2_i <= 0;
		end
		$display("test attention done");
		wb(1, 4'h8, 32'h0000fffd);
		wb(1, 4'h0, 32'h4101);
		repeat (2) @(posedge clk_i);
		chk("armed", ready_o, 0);
		wait (ready_o === 1'b1);
		chk("words", n_busy, 3);
		chk("link data", link_data_o, 16'h5a3c);
		chk("mem we rd", mem_we_o, 0);
		wb(0, 4'h8, 0);
		chk("wcr", rd[15:0], 0);
		$display("test dma done");
		wb(1, 4'h8, 32'h0000fff0);
		wb(1, 4'h0, 32'h4001);
		repeat (2) @(posedge clk_i);
		chk("go armed", ready_o, 0);
		peer_func2_i <= 1;
		repeat (3) @(posedge clk_i);
		chk("attn stop", ready_o, 1);
		peer_func2_i <= 0;
		$display("test attention stop done");
		wb(1, 4'h8, 32'h0000ffff);
		wb(1, 4'h0, 32'h410b);
		wait (ready_o === 1'b1);
		chk("words wr", n_busy, 4);
		chk("mem we wr", mem_we_o, 1);
		chk("mem wdata", mem_wdata_o, 16'h0f0f);
		chk("inhibit", peer_burst_inhibit_out, 1);
		$display("test dma write done");
		stop_test;
	end
endmodule
bind dlcc_link dlcc_link_sva #(.GO_PULSE_CYC(GO_PULSE_CYC)) u_sva (.*);
`default_nettype wire
